/* logic/cif_pick.sv */
// unified priority picker over the pending interrupt slots
`timescale 1ns/10ps
module cif_pick
  import cif_pkg::*;
(
  input  wire logic [SLOTS-1:0]  pend,
  input  wire logic [PRIO_W-1:0] prio [SLOTS],
  input  wire logic [SLOTS-1:0]  grp,
  input  wire logic [1:0]        grp_en,
  output logic                   hp_valid,
  output logic [SLOT_W-1:0]      hp_slot,
  output logic [PRIO_W-1:0]      hp_prio
);
  logic [SLOTS-1:0] elig;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++)
    begin : g_elig
      assign elig[g] = pend[g] & grp_en[grp[g]];
    end
  endgenerate

  // one comparison chain for both groups; ties go to the lower slot
  always_comb
  begin
    hp_valid = 1'b0;
    hp_slot  = '0;
    hp_prio  = PRIO_IDLE;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (elig[i] && (!hp_valid || prio[i] < hp_prio))
      begin
        hp_valid = 1'b1;
        hp_slot  = SLOT_W'(i);
        hp_prio  = prio[i];
      end
    end
  end
endmodule : cif_pick

/* logic/cif_top.sv */
// per-core interrupt cpu interface with strap-selected bypass
//
// Behaviour
// - strap high at reset disables internal interface
// - bypass: virtual request pins drive core
// - register access while bypassed returns undefined
// - enabled: interface itself makes virtual requests
// - group 0 signalled on fast request only
// - group 1 on normal or fast request
// - own instance per core, shared distributor
// - registers mask, identify, control interrupt state
// - one priority scheme across both groups
// - each interrupt's group decides its signalling
`timescale 1ns/10ps
module cif_top
  import cif_pkg::*;
#(
  parameter logic [TGT_W-1:0] CORE_INDEX = 3'h0
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              cpu_if_disable_strap,
  input  wire logic              virtual_irq_req_n,
  input  wire logic              virtual_fast_req_n,
  input  wire logic              physical_int_req_n,
  input  wire logic              physical_fast_req_n,
  input  wire logic              dist_valid,
  input  wire logic [TGT_W-1:0]  dist_target,
  input  wire logic [ID_W-1:0]   dist_id,
  input  wire logic [PRIO_W-1:0] dist_prio,
  input  wire logic              dist_grp,
  input  wire logic              sr_req,
  input  wire logic              sr_write,
  input  wire logic [IDX_W-1:0]  sr_idx,
  input  wire logic [DATA_W-1:0] sr_wdata,
  output logic                   sr_ack,
  output logic                   sr_undef,
  output logic [DATA_W-1:0]      sr_rdata,
  output logic                   core_virq_n,
  output logic                   core_vfiq_n,
  output logic                   core_pirq_n,
  output logic                   core_pfiq_n,
  output logic                   cpu_if_bypassed
);
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  cif_mode_t         mode_ff;
  logic              byp_ff;
  logic [1:0]        settle_ff;
  logic [SLOTS-1:0]  pend_ff;
  logic [SLOTS-1:0]  grp_ff;
  logic [PRIO_W-1:0] prio_ff [SLOTS];
  logic [ID_W-1:0]   id_ff [SLOTS];
  logic [PRIO_W-1:0] pmr_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic              act_ff;
  logic [ID_W-1:0]   act_id_ff;
  logic [PRIO_W-1:0] act_prio_ff;
  logic              virq_n_ff;
  logic              vfiq_n_ff;
  logic              pirq_n_ff;
  logic              pfiq_n_ff;
  logic              ack_ff;
  logic              undef_ff;
  logic [DATA_W-1:0] rdata_ff;

  wire logic              enabled;
  wire logic              bypass;
  wire logic              dist_hit;
  wire logic              sr_take;
  wire logic              ack_hit;
  wire logic              eoi_hit;
  wire logic              preempt;
  wire logic              hp_valid;
  wire logic [SLOT_W-1:0] hp_slot;
  wire logic [PRIO_W-1:0] hp_prio;
  wire logic              hp_grp;
  wire logic [ID_W-1:0]   hp_id;
  wire logic [PRIO_W-1:0] run_prio;
  wire logic [ID_W-1:0]   ack_id;
  wire logic [ID_W-1:0]   hpend_id;
  wire logic              want_fiq;
  wire logic              nxt_virq_n;
  wire logic              nxt_vfiq_n;
  wire logic [DATA_W-1:0] nxt_rdata;
  wire logic [SYNC_W-1:0] pins;
  wire logic [SLOTS-1:0]  beats;

  assign pins = {cpu_if_disable_strap, virtual_irq_req_n,
                 virtual_fast_req_n, physical_int_req_n,
                 physical_fast_req_n};

  // all pins come from outside the core clock
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end
    else
    begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  // wait for the synchroniser to fill before trusting the strap
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff   <= CIF_SAMPLE;
      settle_ff <= 2'h0;
      byp_ff    <= 1'b0;
    end
    else
    begin
      unique case (mode_ff)
        CIF_SAMPLE:
        begin
          if (settle_ff == STRAP_SETTLE)
          begin
            mode_ff <= sync2_ff[SYNC_STRAP] ? CIF_BYPASS
                                            : CIF_INTERNAL;
            byp_ff  <= sync2_ff[SYNC_STRAP];
          end
          else
            settle_ff <= settle_ff + 2'h1;
        end
        CIF_INTERNAL: mode_ff <= CIF_INTERNAL;
        CIF_BYPASS:   mode_ff <= CIF_BYPASS;
        default:      mode_ff <= CIF_SAMPLE;
      endcase
    end
  end

  assign enabled  = (mode_ff == CIF_INTERNAL);
  assign bypass   = (mode_ff == CIF_BYPASS);
  assign dist_hit = dist_valid && enabled
                    && (dist_target == CORE_INDEX);
  assign sr_take  = sr_req && enabled;

  cif_pick u_pick (
    .pend     (pend_ff),
    .prio     (prio_ff),
    .grp      (grp_ff),
    .grp_en   ({ctrl_ff[CTRL_G1_EN], ctrl_ff[CTRL_G0_EN]}),
    .hp_valid (hp_valid),
    .hp_slot  (hp_slot),
    .hp_prio  (hp_prio)
  );

  assign hp_grp   = grp_ff[hp_slot];
  assign hp_id    = id_ff[hp_slot];
  // no nesting: a second interrupt waits for end of the active one
  assign preempt  = hp_valid && !act_ff && (hp_prio < pmr_ff);
  assign run_prio = act_ff ? act_prio_ff : PRIO_IDLE;
  assign ack_hit  = sr_take && !sr_write && (sr_idx == REG_ACK)
                    && preempt;
  assign eoi_hit  = sr_take && sr_write && (sr_idx == REG_EOI)
                    && act_ff && (sr_wdata[ID_W-1:0] == act_id_ff);
  assign ack_id   = ack_hit ? hp_id : ID_SPURIOUS;
  assign hpend_id = preempt ? hp_id : ID_SPURIOUS;

  // group 0 always fast; group 1 picks by control bit
  assign want_fiq   = !hp_grp || ctrl_ff[CTRL_G1_FIQ];
  // virtual pins are ignored when enabled, they are tied off outside
  assign nxt_virq_n = bypass  ? sync2_ff[SYNC_VIRQ]
                    : enabled ? !(preempt && !want_fiq)
                    : 1'b1;
  assign nxt_vfiq_n = bypass  ? sync2_ff[SYNC_VFIQ]
                    : enabled ? !(preempt && want_fiq)
                    : 1'b1;

  assign nxt_rdata =
      (sr_write || !sr_take)  ? '0
    : (sr_idx == REG_PMR)     ? DATA_W'(pmr_ff)
    : (sr_idx == REG_CTRL)    ? DATA_W'(ctrl_ff)
    : (sr_idx == REG_ACK)     ? DATA_W'(ack_id)
    : (sr_idx == REG_HPEND)   ? DATA_W'(hpend_id)
    : (sr_idx == REG_RUN)     ? DATA_W'(run_prio)
    : '0;

  genvar s;
  generate
    for (s = 0; s < SLOTS; s++)
    begin : g_slot
      wire logic set_s;
      wire logic clr_s;
      assign set_s = dist_hit && (dist_id[SLOT_W-1:0] == SLOT_W'(s));
      assign clr_s = ack_hit && (hp_slot == SLOT_W'(s));
      // checker helper: an eligible slot more urgent than the pick
      assign beats[s] = pend_ff[s]
                        && (grp_ff[s] ? ctrl_ff[CTRL_G1_EN]
                                      : ctrl_ff[CTRL_G0_EN])
                        && (prio_ff[s] < hp_prio);
      // a new arrival beats the acknowledge clear
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pend_ff[s] <= 1'b0;
          grp_ff[s]  <= 1'b0;
          prio_ff[s] <= PRIO_IDLE;
          id_ff[s]   <= ID_SPURIOUS;
        end
        else if (set_s)
        begin
          pend_ff[s] <= 1'b1;
          grp_ff[s]  <= dist_grp;
          prio_ff[s] <= dist_prio;
          id_ff[s]   <= dist_id;
        end
        else if (clr_s)
          pend_ff[s] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pmr_ff  <= PMR_RST;
      ctrl_ff <= CTRL_RST;
    end
    else if (sr_take && sr_write && sr_idx == REG_PMR)
      pmr_ff <= sr_wdata[PRIO_W-1:0];
    else if (sr_take && sr_write && sr_idx == REG_CTRL)
      ctrl_ff <= sr_wdata[CTRL_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_ff      <= 1'b0;
      act_id_ff   <= ID_SPURIOUS;
      act_prio_ff <= PRIO_IDLE;
    end
    else if (ack_hit)
    begin
      act_ff      <= 1'b1;
      act_id_ff   <= hp_id;
      act_prio_ff <= hp_prio;
    end
    else if (eoi_hit)
      act_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      virq_n_ff <= 1'b1;
      vfiq_n_ff <= 1'b1;
      pirq_n_ff <= 1'b1;
      pfiq_n_ff <= 1'b1;
      ack_ff    <= 1'b0;
      undef_ff  <= 1'b0;
      rdata_ff  <= '0;
    end
    else
    begin
      virq_n_ff <= nxt_virq_n;
      vfiq_n_ff <= nxt_vfiq_n;
      pirq_n_ff <= sync2_ff[SYNC_PIRQ];
      pfiq_n_ff <= sync2_ff[SYNC_PFIQ];
      ack_ff    <= sr_req;
      undef_ff  <= sr_req && !enabled;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign sr_ack          = ack_ff;
  assign sr_undef        = undef_ff;
  assign sr_rdata        = rdata_ff;
  assign core_virq_n     = virq_n_ff;
  assign core_vfiq_n     = vfiq_n_ff;
  assign core_pirq_n     = pirq_n_ff;
  assign core_pfiq_n     = pfiq_n_ff;
  assign cpu_if_bypassed = byp_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_mode_held_stable: assert property (
    (mode_ff != CIF_SAMPLE) |=> $stable(mode_ff))
    else $error("mode changed after strap latch");
  a_strap_sel_bypass: assert property (
    (mode_ff == CIF_SAMPLE && settle_ff == STRAP_SETTLE)
    |=> (bypass == $past(sync2_ff[SYNC_STRAP])))
    else $error("strap not honoured at latch");
  a_bypass_virq_pass: assert property (
    bypass ##1 bypass |-> (core_virq_n == $past(sync2_ff[SYNC_VIRQ]))
      && (core_vfiq_n == $past(sync2_ff[SYNC_VFIQ])))
    else $error("virtual pins not passed in bypass");
  a_undef_when_off: assert property (
    sr_req |=> sr_ack && (sr_undef == ($past(mode_ff) != CIF_INTERNAL)))
    else $error("undefined answer wrong");
  a_grp0_fast_only: assert property (
    (enabled && preempt && !hp_grp)
    |=> !core_vfiq_n && core_virq_n)
    else $error("group 0 not on fast request");
  a_grp1_route_sel: assert property (
    (enabled && preempt && hp_grp)
    |=> (core_vfiq_n == !$past(ctrl_ff[CTRL_G1_FIQ]))
      && (core_virq_n == $past(ctrl_ff[CTRL_G1_FIQ])))
    else $error("group 1 routed wrongly");
  a_internal_quiet: assert property (
    (enabled && !preempt) |=> core_virq_n && core_vfiq_n)
    else $error("request raised with nothing eligible");
  a_ack_marks_act: assert property (
    ack_hit |=> act_ff && (sr_rdata == DATA_W'(act_id_ff))
      && (act_prio_ff < $past(pmr_ff)))
    else $error("acknowledge did not activate");
  a_unified_prio: assert property (
    hp_valid |-> (beats == '0))
    else $error("more urgent eligible slot left waiting");
  a_target_filter: assert property (
    (dist_valid && dist_target != CORE_INDEX && !sr_req)
    |=> $stable(pend_ff))
    else $error("foreign interrupt accepted");
endmodule : cif_top

/* shared/cif_pkg.sv */
// constants and types shared by the cpu interrupt interface design
package cif_pkg;
  localparam int unsigned SLOTS  = 8;
  localparam int unsigned SLOT_W = 3;
  localparam int unsigned ID_W   = 10;
  localparam int unsigned PRIO_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 3;
  localparam int unsigned TGT_W  = 3;
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned SYNC_W = 5;

  localparam logic [IDX_W-1:0] REG_PMR   = 3'h0;
  localparam logic [IDX_W-1:0] REG_CTRL  = 3'h1;
  localparam logic [IDX_W-1:0] REG_ACK   = 3'h2;
  localparam logic [IDX_W-1:0] REG_EOI   = 3'h3;
  localparam logic [IDX_W-1:0] REG_HPEND = 3'h4;
  localparam logic [IDX_W-1:0] REG_RUN   = 3'h5;

  localparam int unsigned CTRL_G0_EN  = 0;
  localparam int unsigned CTRL_G1_EN  = 1;
  localparam int unsigned CTRL_G1_FIQ = 2;

  localparam int unsigned SYNC_STRAP = 4;
  localparam int unsigned SYNC_VIRQ  = 3;
  localparam int unsigned SYNC_VFIQ  = 2;
  localparam int unsigned SYNC_PIRQ  = 1;
  localparam int unsigned SYNC_PFIQ  = 0;

  localparam logic [SYNC_W-1:0] SYNC_RST     = 5'h0f;
  localparam logic [PRIO_W-1:0] PMR_RST      = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_IDLE    = 8'hff;
  localparam logic [ID_W-1:0]   ID_SPURIOUS  = 10'h3ff;
  localparam logic [1:0]        STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    CIF_SAMPLE,
    CIF_INTERNAL,
    CIF_BYPASS
  } cif_mode_t;
endpackage : cif_pkg

/* verif/cif_dist_model.sv */
// distributor model feeding the cpu interface
`timescale 1ns/10ps
module cif_dist_model
  import cif_pkg::*;
(
  input  wire logic         ref_clk,
  output logic              dist_valid,
  output logic [TGT_W-1:0]  dist_target,
  output logic [ID_W-1:0]   dist_id,
  output logic [PRIO_W-1:0] dist_prio,
  output logic              dist_grp
);
  initial
  begin
    dist_valid = 1'b0;
    dist_target = '0;
    dist_id = '0;
    dist_prio = '0;
    dist_grp = 1'b0;
  end

  // one pulse per delivery, target picks the core
  task automatic send(input logic [TGT_W-1:0] t, input logic [ID_W-1:0] i,
                      input logic [PRIO_W-1:0] p, input logic g);
    @(negedge ref_clk);
    dist_valid = 1'b1;
    dist_target = t;
    dist_id = i;
    dist_prio = p;
    dist_grp = g;
    @(negedge ref_clk);
    dist_valid = 1'b0;
    // stale fields inverted so nothing leans on them after valid drops
    dist_target = ~t;
    dist_id = ~i;
    dist_prio = ~p;
    dist_grp = ~g;
  endtask : send
endmodule : cif_dist_model

/* verif/tb_top.sv */
// testbench for the cpu interrupt interface
`timescale 1ns/10ps
module tb_top
  import cif_pkg::*;
;
  logic              ref_clk, rst_n, cpu_if_disable_strap;
  logic              virtual_irq_req_n, virtual_fast_req_n;
  logic              physical_int_req_n, physical_fast_req_n;
  logic              sr_req, sr_write, sr_ack, sr_undef;
  logic [IDX_W-1:0]  sr_idx;
  logic [DATA_W-1:0] sr_wdata, sr_rdata;
  logic              core_virq_n, core_vfiq_n, core_pirq_n, core_pfiq_n;
  logic              cpu_if_bypassed, dist_valid, dist_grp;
  logic [TGT_W-1:0]  dist_target;
  logic [ID_W-1:0]   dist_id;
  logic [PRIO_W-1:0] dist_prio;
  int                fails, n_tests;

  cif_top #(.CORE_INDEX(3'h0)) cif_top_i (
    .ref_clk, .rst_n, .cpu_if_disable_strap, .virtual_irq_req_n,
    .virtual_fast_req_n, .physical_int_req_n, .physical_fast_req_n,
    .dist_valid, .dist_target, .dist_id, .dist_prio, .dist_grp,
    .sr_req, .sr_write, .sr_idx, .sr_wdata, .sr_ack, .sr_undef,
    .sr_rdata, .core_virq_n, .core_vfiq_n, .core_pirq_n, .core_pfiq_n,
    .cpu_if_bypassed
  );
  cif_dist_model cif_dist_model_i (
    .ref_clk, .dist_valid, .dist_target, .dist_id, .dist_prio, .dist_grp
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask : chk1

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // answer is fixed at one edge after the take, so no wait loop
  task automatic acc(input logic w, input logic [IDX_W-1:0] i,
                     input logic [31:0] d, input logic eu,
                     output logic [31:0] q);
    @(negedge ref_clk);
    sr_req = 1'b1;
    sr_write = w;
    sr_idx = i;
    sr_wdata = d;
    @(negedge ref_clk);
    sr_req = 1'b0;
    chk1("sr_ack", 1'b1, sr_ack);
    chk1("sr_undef", eu, sr_undef);
    q = sr_rdata;
  endtask : acc

  task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, i, d, 1'b0, q);
    cyc(2);
  endtask : wr

  task automatic rd(input string nm, input logic [IDX_W-1:0] i,
                    input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, i, 32'h0000_0000, 1'b0, q);
    chk(nm, e, q);
  endtask : rd

  task automatic restart(input logic s);
    @(negedge ref_clk);
    rst_n = 1'b0;
    cpu_if_disable_strap = s;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    cyc(3);
  endtask : restart

  task automatic s_internal;
    restart(1'b0);
    chk1("bypassed", 1'b0, cpu_if_bypassed);
    rd("pmr rst", REG_PMR, 32'h0000_0000);
    rd("ctrl rst", REG_CTRL, 32'h0000_0000);
    rd("unmapped", 3'h7, 32'h0000_0000);
    wr(REG_PMR, 32'h0000_01ff);
    rd("pmr", REG_PMR, 32'h0000_00ff);
    wr(REG_CTRL, 32'h0000_0003);
    rd("ctrl", REG_CTRL, 32'h0000_0003);
  endtask : s_internal

  task automatic s_group0;
    cif_dist_model_i.send(3'h0, 10'h005, 8'h10, 1'b0);
    cyc(2);
    chk1("vfiq g0", 1'b0, core_vfiq_n);
    chk1("virq g0", 1'b1, core_virq_n);
    rd("ack", REG_ACK, 32'h0000_0005);
    cyc(1);
    chk1("vfiq acked", 1'b1, core_vfiq_n);
    rd("run", REG_RUN, 32'h0000_0010);
    wr(REG_EOI, 32'h0000_0005);
    rd("run idle", REG_RUN, 32'(PRIO_IDLE));
  endtask : s_group0

  task automatic s_prio;
    cif_dist_model_i.send(3'h0, 10'h002, 8'h40, 1'b0);
    cif_dist_model_i.send(3'h1, 10'h007, 8'h01, 1'b1);
    cif_dist_model_i.send(3'h0, 10'h003, 8'h20, 1'b1);
    cyc(2);
    chk1("virq g1", 1'b0, core_virq_n);
    chk1("vfiq g1", 1'b1, core_vfiq_n);
    rd("hpend", REG_HPEND, 32'h0000_0003);
    wr(REG_CTRL, 32'h0000_0007);
    chk1("vfiq g1f", 1'b0, core_vfiq_n);
    chk1("virq g1f", 1'b1, core_virq_n);
    rd("ack hi", REG_ACK, 32'h0000_0003);
    wr(REG_EOI, 32'h0000_0003);
    rd("ack lo", REG_ACK, 32'h0000_0002);
    wr(REG_EOI, 32'h0000_0002);
    rd("none", REG_HPEND, 32'(ID_SPURIOUS));
    wr(REG_PMR, 32'h0000_0000);
    cif_dist_model_i.send(3'h0, 10'h004, 8'h10, 1'b0);
    cyc(2);
    chk1("masked", 1'b1, core_vfiq_n);
    wr(REG_PMR, 32'h0000_00ff);
    chk1("unmasked", 1'b0, core_vfiq_n);
    rd("ack pmr", REG_ACK, 32'h0000_0004);
    wr(REG_EOI, 32'h0000_0004);
  endtask : s_prio

  task automatic s_phys;
    @(negedge ref_clk);
    physical_int_req_n = 1'b0;
    physical_fast_req_n = 1'b0;
    cyc(2);
    chk1("pirq early", 1'b1, core_pirq_n);
    cyc(1);
    chk1("pirq", 1'b0, core_pirq_n);
    chk1("pfiq", 1'b0, core_pfiq_n);
    @(negedge ref_clk);
    physical_int_req_n = 1'b1;
    physical_fast_req_n = 1'b1;
  endtask : s_phys

  task automatic s_bypass;
    logic [31:0] q;
    restart(1'b1);
    chk1("bypassed", 1'b1, cpu_if_bypassed);
    @(negedge ref_clk);
    cpu_if_disable_strap = 1'b0;
    virtual_irq_req_n = 1'b0;
    cyc(2);
    chk1("virq early", 1'b1, core_virq_n);
    cyc(1);
    chk1("virq bypass", 1'b0, core_virq_n);
    cif_dist_model_i.send(3'h0, 10'h001, 8'h00, 1'b0);
    cyc(2);
    chk1("vfiq ignored", 1'b1, core_vfiq_n);
    @(negedge ref_clk);
    virtual_fast_req_n = 1'b0;
    cyc(3);
    chk1("vfiq bypass", 1'b0, core_vfiq_n);
    acc(1'b0, REG_PMR, 32'h0000_0000, 1'b1, q);
    chk("undef data", 32'h0000_0000, q);
    chk1("mode held", 1'b1, cpu_if_bypassed);
  endtask : s_bypass

  initial
  begin
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    cpu_if_disable_strap = 1'b0;
    virtual_irq_req_n = 1'b1;
    virtual_fast_req_n = 1'b1;
    physical_int_req_n = 1'b1;
    physical_fast_req_n = 1'b1;
    sr_req = 1'b0;
    sr_write = 1'b0;
    sr_idx = '0;
    sr_wdata = '0;
    s_internal;
    s_group0;
    s_prio;
    s_phys;
    s_bypass;
    test_done;
  end

  // hang guard at 50000 cycles, far above the under two hundred the test uses
  initial
  begin
    #1000000;
    fails++;
    test_done;
  end
endmodule : tb_top
